/* File: hw/pmicw_ctl.sv */
/*
 * Controller end: APB slave registers order one write transfer
 * (address, index, data) and the link is driven by a divided pclk.
 * Assumes the target does not stretch the clock.
 */
`timescale 1ns/10ps
module pmicw_ctl (
   input wire logic pclk,
   input wire logic presetn,
   pmicw_if.ctl bus,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // ----------------------------------------------------------------
   // apb slave, no wait states
   // ----------------------------------------------------------------
   logic [7:0] index_r;
   logic [7:0] data_r;
   logic [6:0] taddr_r;
   logic busy_r;
   logic nack_r;
   logic wr_acc;
   logic go;
   logic mapped;
   logic nack_set;

   assign mapped = paddr == pmicw_pkg::OFS_INDEX || paddr == pmicw_pkg::OFS_DATA
                   || paddr == pmicw_pkg::OFS_CMD || paddr == pmicw_pkg::OFS_STATUS
                   || paddr == pmicw_pkg::OFS_TADDR;
   assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
   assign go = wr_acc && paddr == pmicw_pkg::OFS_CMD
               && pwdata[pmicw_pkg::CMD_GO_BIT] && !busy_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'h0;
         pslverr <= 1'h0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            unique case (paddr)
               pmicw_pkg::OFS_INDEX: prdata <= {24'h00_0000, index_r};
               pmicw_pkg::OFS_DATA: prdata <= {24'h00_0000, data_r};
               pmicw_pkg::OFS_STATUS: prdata <= {30'h0000_0000, nack_r, busy_r};
               pmicw_pkg::OFS_TADDR: prdata <= {25'h000_0000, taddr_r};
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         index_r <= 8'h00;
         data_r <= 8'h00;
         taddr_r <= pmicw_pkg::TGT_ADDR7_RST;
      end else if (wr_acc) begin
         if (paddr == pmicw_pkg::OFS_INDEX) index_r <= pwdata[7:0];
         if (paddr == pmicw_pkg::OFS_DATA) data_r <= pwdata[7:0];
         if (paddr == pmicw_pkg::OFS_TADDR) taddr_r <= pwdata[6:0];
      end
   end

   // ----------------------------------------------------------------
   // link sequencer, four quarter steps per bit
   // ----------------------------------------------------------------
   pmicw_pkg::pmicw_cstate_t st_r;
   logic [2:0] qcnt_r;
   logic [1:0] qph_r;
   logic [3:0] bit_r;
   logic [1:0] byte_r;
   logic [7:0] sh_r;
   logic scl_oe_r;
   logic sda_oe_r;
   logic sda_m_r;
   logic sda_s_r;
   logic tick;

   assign tick = qcnt_r == pmicw_pkg::QTR_CYCLES - 3'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_m_r <= 1'h1;
         sda_s_r <= 1'h1;
      end else begin
         sda_m_r <= bus.sda;
         sda_s_r <= sda_m_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qcnt_r <= 3'h0;
      end else if (st_r == pmicw_pkg::C_IDLE || tick) begin
         qcnt_r <= 3'h0;
      end else begin
         qcnt_r <= qcnt_r + 3'h1;
      end
   end

   assign nack_set = st_r == pmicw_pkg::C_BIT && tick && qph_r == 2'h2
                     && bit_r == pmicw_pkg::ACK_SLOT && sda_s_r;

   // a nack in the same cycle as go stays visible: set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nack_r <= 1'h0;
      end else if (nack_set) begin
         nack_r <= 1'h1;
      end else if (go) begin
         nack_r <= 1'h0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= pmicw_pkg::C_IDLE;
         qph_r <= 2'h0;
         bit_r <= 4'h0;
         byte_r <= 2'h0;
         sh_r <= 8'h00;
         scl_oe_r <= 1'h0;
         sda_oe_r <= 1'h0;
         busy_r <= 1'h0;
      end else if (st_r == pmicw_pkg::C_IDLE) begin
         qph_r <= 2'h0;
         if (go) begin
            st_r <= pmicw_pkg::C_START;
            busy_r <= 1'h1;
         end
      end else if (tick) begin
         qph_r <= qph_r + 2'h1;
         unique case (st_r)
            pmicw_pkg::C_START: begin
               if (qph_r == 2'h0) begin
                  sda_oe_r <= 1'h1;
               end else if (qph_r == 2'h1) begin
                  scl_oe_r <= 1'h1;
                  st_r <= pmicw_pkg::C_BIT;
                  qph_r <= 2'h0;
                  bit_r <= 4'h0;
                  byte_r <= 2'h0;
                  sh_r <= {taddr_r, 1'h0};
               end
            end
            pmicw_pkg::C_BIT: begin
               unique case (qph_r)
                  2'h0: sda_oe_r <= (bit_r != pmicw_pkg::ACK_SLOT) && !sh_r[7];
                  2'h1: scl_oe_r <= 1'h0;
                  2'h2: ;
                  2'h3: begin
                     scl_oe_r <= 1'h1;
                     if (bit_r != pmicw_pkg::ACK_SLOT) begin
                        bit_r <= bit_r + 4'h1;
                        sh_r <= {sh_r[6:0], 1'h0};
                     end else if (nack_r || byte_r == pmicw_pkg::LAST_BYTE) begin
                        st_r <= pmicw_pkg::C_STOP;
                     end else begin
                        bit_r <= 4'h0;
                        byte_r <= byte_r + 2'h1;
                        sh_r <= (byte_r == 2'h0) ? index_r : data_r;
                     end
                  end
               endcase
            end
            pmicw_pkg::C_STOP: begin
               unique case (qph_r)
                  2'h0: sda_oe_r <= 1'h1;
                  2'h1: scl_oe_r <= 1'h0;
                  2'h2: sda_oe_r <= 1'h0;
                  2'h3: begin
                     st_r <= pmicw_pkg::C_IDLE;
                     busy_r <= 1'h0;
                  end
               endcase
            end
            default: st_r <= pmicw_pkg::C_IDLE;
         endcase
      end
   end

   assign bus.ctl_scl_oe = scl_oe_r;
   assign bus.ctl_sda_oe = sda_oe_r;
   assign bus.ctl_scl_o = 1'h0;
   assign bus.ctl_sda_o = 1'h0;

endmodule : pmicw_ctl

/* File: hw/pmicw_if.sv */
/*
 * Two-wire open-drain link between controller and target.
 * Assumes pull-ups: a line is low only while some end enables a low drive.
 */
`timescale 1ns/10ps
interface pmicw_if;
   logic ctl_scl_o;
   logic ctl_scl_oe;
   logic ctl_sda_o;
   logic ctl_sda_oe;
   logic tgt_sda_o;
   logic tgt_sda_oe;
   logic scl;
   logic sda;

   // ----------------------------------------------------------------
   // wired-and with pull-up
   // ----------------------------------------------------------------
   assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
   assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (tgt_sda_oe & ~tgt_sda_o));

   modport ctl (output ctl_scl_o, ctl_scl_oe, ctl_sda_o, ctl_sda_oe, input scl, sda);
   modport tgt (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface : pmicw_if

/* File: hw/pmicw_pkg.sv */
/*
 * Shared constants and types for the write-only two-wire configuration link:
 * target address, register indices, field positions, controller register map.
 * Assumes a single-master bus with external pull-ups on both lines.
 */
package pmicw_pkg;

   // ----------------------------------------------------------------
   // link framing
   // ----------------------------------------------------------------
   localparam logic [7:0] TGT_ADDR_BYTE = 8'h98;
   localparam logic [6:0] TGT_ADDR7_RST = 7'h4c;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [7:0] IDX_MAX = 8'hff;

   // ----------------------------------------------------------------
   // target registers
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_CHARGER = 8'h00;
   localparam logic [7:0] IDX_PATH_REG1 = 8'h01;
   localparam logic [7:0] IDX_REG_VSEL = 8'h02;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam int WDOG_OFF_BIT = 7;
   localparam int RECHARGE_LSB = 5;
   localparam int CODE_LSB = 2;
   localparam int CODE_MSB = 4;
   localparam int TERM_LSB = 0;
   localparam int PATH_SEL_BIT = 2;
   localparam int REG1_LSB = 0;
   localparam logic [7:0] PATH_REG1_USED = 8'h07;
   localparam logic [2:0] CODE_DEFAULT = 3'h0;
   localparam logic [7:0] PCT_NONE = 8'h00;

   // ----------------------------------------------------------------
   // controller registers (byte addresses) and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_INDEX = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_CMD = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_TADDR = 8'h10;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
   localparam int CMD_GO_BIT = 0;
   localparam logic [2:0] QTR_CYCLES = 3'h4;
   localparam logic [1:0] LAST_BYTE = 2'h2;

   typedef enum logic [1:0] {
      T_IDLE = 2'b00,
      T_ADDR = 2'b01,
      T_INDEX = 2'b10,
      T_DATA = 2'b11
   } pmicw_tphase_t;

   typedef enum logic [1:0] {
      C_IDLE = 2'b00,
      C_START = 2'b01,
      C_BIT = 2'b10,
      C_STOP = 2'b11
   } pmicw_cstate_t;

   // charge current as percent of the resistor-set level
   function automatic logic [7:0] pmicw_pct(input logic [2:0] code);
      logic [7:0] p;
      p = 8'h00;
      unique case (code)
         3'h0: p = 8'h64;
         3'h1: p = 8'h50;
         3'h2: p = 8'h3c;
         3'h3: p = 8'h28;
         3'h4: p = 8'h78;
         3'h5: p = 8'h8c;
         3'h6: p = 8'ha0;
         3'h7: p = 8'hb4;
      endcase
      return p;
   endfunction : pmicw_pct

endpackage : pmicw_pkg

/* File: hw/pmicw_target.sv */
/*
 * Target end: receives address, index and data bytes on the link clock,
 * hands each write to index 0 to 2 to the system clock domain, holds three configuration
 * registers and derives the effective charge settings from power state.
 * Assumes the controller never stretches or reads and keeps link timing.
 */
`timescale 1ns/10ps

module pmicw_target (
   input wire logic pclk,
   input wire logic presetn,
   pmicw_if.tgt bus,
   input wire logic usb_mode,
   input wire logic key_power_on,
   input wire logic hold_enable,
   input wire logic charger_supply_input,
   input wire logic battery_present,
   output logic [7:0] charger_control,
   output logic [7:0] power_path_and_regulator_one,
   output logic [7:0] regulator_voltage_select,
   output logic [2:0] effective_charge_code,
   output logic [7:0] charge_percent,
   output logic fixed_charge_100ma,
   output logic powered
);

   // ----------------------------------------------------------------
   // start detection, clocked by the data line
   // ----------------------------------------------------------------
   // sampled on the next clock rise; the bus guarantees the start edge
   // settles a full half period earlier, so no extra stage is needed
   logic start_tgl_r;
   logic start_seen_r;
   logic new_start;

   always_ff @(negedge bus.sda or negedge presetn) begin
      if (!presetn) begin
         start_tgl_r <= 1'h0;
      end else if (bus.scl) begin
         start_tgl_r <= ~start_tgl_r;
      end
   end

   assign new_start = start_tgl_r ^ start_seen_r;

   // ----------------------------------------------------------------
   // link-side receiver
   // ----------------------------------------------------------------
   pmicw_pkg::pmicw_tphase_t phase_r;
   logic [3:0] bit_cnt_r;
   logic [6:0] shift_r;
   logic [7:0] idx_r;
   logic ack_want_r;
   logic [7:0] wr_idx_r;
   logic [7:0] wr_dat_r;
   logic wr_tgl_r;
   logic [7:0] rx_byte;

   assign rx_byte = {shift_r, bus.sda};

   always_ff @(posedge bus.scl or negedge presetn) begin
      if (!presetn) begin
         start_seen_r <= 1'h0;
      end else begin
         start_seen_r <= start_tgl_r;
      end
   end

   always_ff @(posedge bus.scl or negedge presetn) begin
      if (!presetn) begin
         bit_cnt_r <= 4'h0;
         shift_r <= 7'h00;
      end else if (new_start) begin
         bit_cnt_r <= 4'h1;
         shift_r <= {6'h00, bus.sda};
      end else if (bit_cnt_r == pmicw_pkg::ACK_SLOT) begin
         bit_cnt_r <= 4'h0;
      end else begin
         bit_cnt_r <= bit_cnt_r + 4'h1;
         shift_r <= rx_byte[6:0];
      end
   end

   always_ff @(posedge bus.scl or negedge presetn) begin
      if (!presetn) begin
         phase_r <= pmicw_pkg::T_IDLE;
         ack_want_r <= 1'h0;
         idx_r <= 8'h00;
      end else if (new_start) begin
         phase_r <= pmicw_pkg::T_ADDR;
         ack_want_r <= 1'h0;
      end else if (bit_cnt_r == pmicw_pkg::LAST_DATA_BIT) begin
         unique case (phase_r)
            pmicw_pkg::T_IDLE: begin
               ack_want_r <= 1'h0;
            end
            pmicw_pkg::T_ADDR: begin
               // a read request never matches, so reads are never taken
               if (rx_byte == pmicw_pkg::TGT_ADDR_BYTE) begin
                  ack_want_r <= 1'h1;
                  phase_r <= pmicw_pkg::T_INDEX;
               end else begin
                  ack_want_r <= 1'h0;
                  phase_r <= pmicw_pkg::T_IDLE;
               end
            end
            pmicw_pkg::T_INDEX: begin
               idx_r <= rx_byte;
               ack_want_r <= 1'h1;
               phase_r <= pmicw_pkg::T_DATA;
            end
            pmicw_pkg::T_DATA: begin
               ack_want_r <= 1'h1;
               if (idx_r != pmicw_pkg::IDX_MAX) begin
                  idx_r <= idx_r + 8'h01;
               end
            end
         endcase
      end
   end

   // write hand-over: index and data stay put for a whole byte time
   always_ff @(posedge bus.scl or negedge presetn) begin
      if (!presetn) begin
         wr_idx_r <= 8'h00;
         wr_dat_r <= 8'h00;
         wr_tgl_r <= 1'h0;
      end else if (!new_start && bit_cnt_r == pmicw_pkg::LAST_DATA_BIT
                   && phase_r == pmicw_pkg::T_DATA
                   && idx_r <= pmicw_pkg::IDX_REG_VSEL) begin
         wr_idx_r <= idx_r;
         wr_dat_r <= rx_byte;
         wr_tgl_r <= ~wr_tgl_r;
      end
   end

   // ----------------------------------------------------------------
   // acknowledge drive, changed only while the clock is low
   // ----------------------------------------------------------------
   logic sda_oe_r;

   always_ff @(negedge bus.scl or negedge presetn) begin
      if (!presetn) begin
         sda_oe_r <= 1'h0;
      end else begin
         // data only ever moves with the clock low, so no start or stop
         sda_oe_r <= (bit_cnt_r == pmicw_pkg::ACK_SLOT) && ack_want_r;
      end
   end

   assign bus.tgt_sda_oe = sda_oe_r;
   assign bus.tgt_sda_o = 1'h0;

   // ----------------------------------------------------------------
   // system-side synchronisers
   // ----------------------------------------------------------------
   logic [5:0] sync1_r;
   logic [5:0] sync2_r;
   logic wr_prev_r;
   logic usb_s;
   logic key_s;
   logic hold_s;
   logic sup_s;
   logic bat_s;
   logic wr_s;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 6'h00;
         sync2_r <= 6'h00;
         wr_prev_r <= 1'h0;
      end else begin
         sync1_r <= {wr_tgl_r, usb_mode, key_power_on, hold_enable,
                     charger_supply_input, battery_present};
         sync2_r <= sync1_r;
         wr_prev_r <= sync2_r[5];
      end
   end

   assign {wr_s, usb_s, key_s, hold_s, sup_s, bat_s} = sync2_r;

   // ----------------------------------------------------------------
   // power state
   // ----------------------------------------------------------------
   logic on_r;
   logic by_key_r;
   logic sup_prev_r;
   logic force_r;
   logic wr_ev;
   logic shutdown;
   logic sup_rise;

   assign wr_ev = wr_s ^ wr_prev_r;
   assign sup_rise = sup_s & ~sup_prev_r;
   assign shutdown = on_r & ((by_key_r & ~hold_s & ~key_s)
                     | (~bat_s & ~sup_s)
                     | (~by_key_r & ~sup_s));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_r <= 1'h0;
         by_key_r <= 1'h0;
         sup_prev_r <= 1'h0;
      end else begin
         sup_prev_r <= sup_s;
         if (shutdown) begin
            on_r <= 1'h0;
            by_key_r <= 1'h0;
         end else if (key_s) begin
            on_r <= 1'h1;
            by_key_r <= 1'h1;
         end else if (sup_s) begin
            on_r <= 1'h1;
         end
      end
   end

   // a replug arriving with a write still forces the code: set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         force_r <= 1'h0;
      end else if (usb_s && by_key_r && sup_rise && !shutdown) begin
         force_r <= 1'h1;
      end else if (wr_ev || shutdown) begin
         force_r <= 1'h0;
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         charger_control <= pmicw_pkg::REG_RST;
         power_path_and_regulator_one <= pmicw_pkg::REG_RST;
         regulator_voltage_select <= pmicw_pkg::REG_RST;
      end else if (shutdown) begin
         charger_control <= pmicw_pkg::REG_RST;
         power_path_and_regulator_one <= pmicw_pkg::REG_RST;
         regulator_voltage_select <= pmicw_pkg::REG_RST;
      end else if (wr_ev) begin
         unique case (wr_idx_r)
            pmicw_pkg::IDX_CHARGER: charger_control <= wr_dat_r;
            pmicw_pkg::IDX_PATH_REG1: begin
               power_path_and_regulator_one <= wr_dat_r & pmicw_pkg::PATH_REG1_USED;
            end
            pmicw_pkg::IDX_REG_VSEL: regulator_voltage_select <= wr_dat_r;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // effective charge settings
   // ----------------------------------------------------------------
   logic [2:0] code_nxt;

   assign code_nxt = force_r ? pmicw_pkg::CODE_DEFAULT
                     : charger_control[pmicw_pkg::CODE_MSB:pmicw_pkg::CODE_LSB];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         effective_charge_code <= pmicw_pkg::CODE_DEFAULT;
         charge_percent <= pmicw_pkg::PCT_NONE;
         fixed_charge_100ma <= 1'h0;
         powered <= 1'h0;
      end else begin
         effective_charge_code <= code_nxt;
         powered <= on_r;
         fixed_charge_100ma <= usb_s && code_nxt == pmicw_pkg::CODE_DEFAULT;
         if (usb_s && code_nxt == pmicw_pkg::CODE_DEFAULT) begin
            charge_percent <= pmicw_pkg::PCT_NONE;
         end else begin
            charge_percent <= pmicw_pkg::pmicw_pct(code_nxt);
         end
      end
   end

endmodule : pmicw_target

/* File: sim/pmic_i2c_write_config_tb_top.sv */
/* bench for controller and target joined over the two-wire link
   assumes the controller register map and timing of the design package */
`timescale 1ns/10ps
module pmic_i2c_write_config_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic usb_mode = 1'b0, key_power_on = 1'b1, hold_enable = 1'b1;
   logic charger_supply_input = 1'b1, battery_present = 1'b1;
   logic [7:0] cc, pp, rv, pct;
   logic [2:0] eff;
   logic fix, pwr;
   int n_mismatch = 0, total_checks = 0, cyc = 0;
   localparam logic [7:0] PCT [8] = '{8'h64, 8'h50, 8'h3c, 8'h28, 8'h78, 8'h8c, 8'ha0, 8'hb4};
   // index, data, then expected charger, path, voltage registers
   localparam logic [7:0] ROWS [4][5] = '{'{8'h00, 8'h9d, 8'h9d, 8'h00, 8'h00},
      '{8'h01, 8'hff, 8'h9d, 8'h07, 8'h00}, '{8'h02, 8'ha5, 8'h9d, 8'h07, 8'ha5},
      '{8'h03, 8'h3c, 8'h9d, 8'h07, 8'ha5}};
   always #12.5 pclk = ~pclk;
   pmicw_if link();
   pmicw_ctl pmicw_ctl_inst (.pclk(pclk), .presetn(presetn), .bus(link.ctl), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   pmicw_target pmicw_target_inst (.pclk(pclk), .presetn(presetn), .bus(link.tgt),
      .usb_mode(usb_mode), .key_power_on(key_power_on), .hold_enable(hold_enable),
      .charger_supply_input(charger_supply_input), .battery_present(battery_present),
      .charger_control(cc), .power_path_and_regulator_one(pp), .regulator_voltage_select(rv),
      .effective_charge_code(eff), .charge_percent(pct), .fixed_charge_100ma(fix),
      .powered(pwr));
   pmicw_asserts pmicw_asserts_inst (.pclk(pclk), .presetn(presetn),
      .ctl_sda_oe(link.ctl_sda_oe), .tgt_sda_oe(link.tgt_sda_oe), .scl(link.scl),
      .sda(link.sda));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // one write transfer; rd holds the final status word
   task automatic xfer(input logic [7:0] i, input logic [7:0] d);
      apb(1'b1, pmicw_pkg::OFS_INDEX, {24'h0000_00, i});
      apb(1'b1, pmicw_pkg::OFS_DATA, {24'h0000_00, d});
      apb(1'b1, pmicw_pkg::OFS_CMD, 32'h0000_0001);
      rd = 32'h0000_0001;
      for (int k = 0; k < 400 && rd[0] !== 1'b0; k++) apb(1'b0, pmicw_pkg::OFS_STATUS, 0);
      chk("busy", 32'h0000_0000, rd[0]);
      repeat (8) @(posedge pclk);
   endtask : xfer
   task automatic results();
      $display("mismatches %0d checks %0d", n_mismatch, total_checks);
      if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : results
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      chk("reset regs", 32'h0000_0000, {cc, pp, rv, pct});
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      for (int r = 0; r < 4; r++) begin
         xfer(ROWS[r][0], ROWS[r][1]);
         chk("nack", 32'h0000_0000, rd[1]);
         chk("regs", {ROWS[r][2], ROWS[r][3], ROWS[r][4]}, {cc, pp, rv});
      end
      for (int c = 0; c < 8; c++) begin
         xfer(8'h00, 8'(c << 2));
         chk("percent", PCT[c], pct);
      end
      apb(1'b0, 8'h20, 0);
      chk("unmapped", 32'h0000_0001, {rd[30:0], err});
      apb(1'b1, pmicw_pkg::OFS_TADDR, 32'h0000_004d);
      xfer(8'h01, 8'h00);
      chk("foreign nack", {1'b1, 8'h07}, {rd[1], pp});
      apb(1'b1, pmicw_pkg::OFS_TADDR, 32'h0000_004c);
      xfer(8'h00, 8'h08);
      usb_mode <= 1'b1;
      charger_supply_input <= 1'b0;
      repeat (8) @(posedge pclk);
      charger_supply_input <= 1'b1;
      repeat (8) @(posedge pclk);
      chk("forced", {3'h0, 1'b1, 8'h08, 8'h00}, {eff, fix, cc, pct});
      xfer(8'h01, 8'h04);
      chk("restored", {3'h2, 1'b0, 8'h04, PCT[2]}, {eff, fix, pp, pct});
      // charger removed too, otherwise it powers the part straight back up
      key_power_on <= 1'b0;
      hold_enable <= 1'b0;
      charger_supply_input <= 1'b0;
      repeat (8) @(posedge pclk);
      chk("shutdown", 32'h0000_0000, {cc, pp, rv, pwr});
      results();
   end
endmodule : pmic_i2c_write_config_tb_top

/* File: sim/pmicw_asserts.sv */
/* link checker: framing, acknowledge and condition timing on the shared wires
   assumes pclk also paces the controller's link clock and sees every scl edge */
`timescale 1ns/10ps
module pmicw_asserts (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ctl_sda_oe,
   input wire logic tgt_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q_r;
   logic sda_q_r;
   logic first_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end else begin
         scl_q_r <= scl;
         sda_q_r <= sda;
      end
   end
   // bit position since the last start; wraps after the ack slot
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
         first_r <= 1'b0;
         sh_r <= 8'h00;
      end else if (scl && scl_q_r && sda_q_r && !sda) begin
         cnt_r <= 4'h0;
         first_r <= 1'b1;
      end else if (scl && !scl_q_r) begin
         cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
         if (cnt_r == 4'h8) first_r <= 1'b0;
         if (cnt_r < 4'h8) sh_r <= {sh_r[6:0], sda};
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence start_s;
      $fell(sda) && scl;
   endsequence
   sequence stop_s;
      $rose(sda) && scl && $past(scl);
   endsequence
   ack_slot_a: assert property (
      $rose(tgt_sda_oe) |-> cnt_r == 4'h8) else $error("ack outside ninth slot");
   ack_len_a: assert property (
      $rose(tgt_sda_oe) |-> tgt_sda_oe [*8] ##[1:10] !tgt_sda_oe) else $error("ack length");
   ack_release_a: assert property (
      tgt_sda_oe && scl |-> !ctl_sda_oe && !sda) else $error("data not released for ack");
   own_addr_a: assert property (
      $rose(tgt_sda_oe) && first_r |-> sh_r == pmicw_pkg::TGT_ADDR_BYTE)
      else $error("ack of foreign address");
   dir_zero_a: assert property (
      scl && !scl_q_r && first_r && cnt_r == 4'h7 |-> !sda) else $error("direction bit set");
   tgt_no_cond_a: assert property (
      $changed(tgt_sda_oe) |-> !scl) else $error("target moved data while clock high");
   start_order_a: assert property (
      start_s |-> ##[1:8] !scl) else $error("clock did not follow start");
   stop_order_a: assert property (
      stop_s |-> scl [*4]) else $error("clock fell after stop");
   idle_rst_a: assert property (
      $rose(presetn) |-> scl && sda && !tgt_sda_oe) else $error("bus not idle after reset");
endmodule : pmicw_asserts
